//--- rexs_pkg.sv
/*
  package of the reset exception sequencer: sequencer states, vector addresses,
  condition code layout, reset values and timing counts.
  assumes a single 100 MHz system clock.
*/
package rexs_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MIN_HOLD_CYCLES = 10;
  localparam logic [3:0] HOLD_CNT_MAX = 4'(MIN_HOLD_CYCLES);

  // ---------------------------------------------------------------
  // vector and register layout
  // ---------------------------------------------------------------
  localparam logic [15:0] VEC_ADDR_HI = 16'h0000;
  localparam logic [15:0] VEC_ADDR_LO = 16'h0001;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam int unsigned CCR_I_BIT = 7;
  localparam logic [7:0] CCR_RST = 8'h80;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_HELD,
    ST_MASK,
    ST_FETCH_HI,
    ST_FETCH_LO,
    ST_LOAD,
    ST_RUN
  } rexs_state_type;

  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } rexs_fetch_type;

endpackage

//--- rexs_sync.sv
/*
  two flip-flop synchroniser for one level.
  assumes the input may change at any time relative to clk_i.
*/
`timescale 1ns/1ps
module rexs_sync
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // level
  input wire logic async_i,
  output logic sync_o
);

  logic meta_r;
  logic sync_r;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

//--- rexs_sequencer.sv
/*
  reset exception sequencer: holds core and peripherals in reset while the chip
  init pin is low, then masks interrupts, fetches the reset vector, loads the
  program counter and lets execution start.
  assumes a byte-wide program memory answering one cycle after a fetch request.
*/
// Functional notes
// - while pin low, halt processing and hold cpu and peripheral state initial
// - on release after valid hold, start reset exception sequence, not earlier work
// - first step sets interrupt mask bit of condition code register to 1
// - fetch start address from vector 0000-0001, load program counter, execute
`timescale 1ns/1ps
module rexs_sequencer
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // reset pin
  input wire logic chip_init_pin_n_i,
  // vector fetch
  output rexs_pkg::rexs_fetch_type fetch_o,
  input wire logic [7:0] fetch_data_i,
  // core control
  output logic periph_rst_o,
  output logic cpu_run_o,
  output logic [7:0] condition_code_register_o,
  output logic [15:0] pc_o
);

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  logic pin_n_sync;

  rexs_sync u_sync
  (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i(chip_init_pin_n_i),
    .sync_o(pin_n_sync)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  rexs_pkg::rexs_state_type state_r, state_nxt;
  logic [3:0] hold_r, hold_nxt;
  logic armed_r, armed_nxt;
  logic [7:0] ccr_r, ccr_nxt;
  logic [15:0] pc_r, pc_nxt;
  rexs_pkg::rexs_fetch_type fetch_r, fetch_nxt;
  logic prst_r, prst_nxt;
  logic run_r, run_nxt;

  always_comb
  begin
    state_nxt = state_r;
    hold_nxt = hold_r;
    armed_nxt = armed_r;
    ccr_nxt = ccr_r;
    pc_nxt = pc_r;
    fetch_nxt = '0;
    prst_nxt = prst_r;
    run_nxt = run_r;
    if (!pin_n_sync)
    begin
      state_nxt = rexs_pkg::ST_HELD;
      prst_nxt = 1'b1;
      run_nxt = 1'b0;
      ccr_nxt = rexs_pkg::CCR_RST;
      pc_nxt = rexs_pkg::PC_RST;
      if (hold_r != rexs_pkg::HOLD_CNT_MAX)
      begin
        hold_nxt = hold_r + 4'h1;
      end
      if (hold_r == rexs_pkg::HOLD_CNT_MAX - 4'h1)
      begin
        armed_nxt = 1'b1;
      end
    end
    else
    begin
      hold_nxt = 4'h0;
      case (state_r)
        rexs_pkg::ST_HELD:
        begin
          if (armed_r)
          begin
            state_nxt = rexs_pkg::ST_MASK;
            armed_nxt = 1'b0;
          end
        end
        rexs_pkg::ST_MASK:
        begin
          ccr_nxt[rexs_pkg::CCR_I_BIT] = 1'b1;
          fetch_nxt.req = 1'b1;
          fetch_nxt.addr = rexs_pkg::VEC_ADDR_HI;
          state_nxt = rexs_pkg::ST_FETCH_HI;
        end
        rexs_pkg::ST_FETCH_HI:
        begin
          pc_nxt[15:8] = fetch_data_i;
          fetch_nxt.req = 1'b1;
          fetch_nxt.addr = rexs_pkg::VEC_ADDR_LO;
          state_nxt = rexs_pkg::ST_FETCH_LO;
        end
        rexs_pkg::ST_FETCH_LO:
        begin
          pc_nxt[7:0] = fetch_data_i;
          state_nxt = rexs_pkg::ST_LOAD;
        end
        rexs_pkg::ST_LOAD:
        begin
          prst_nxt = 1'b0;
          run_nxt = 1'b1;
          state_nxt = rexs_pkg::ST_RUN;
        end
        rexs_pkg::ST_RUN:
        begin
          state_nxt = rexs_pkg::ST_RUN;
        end
        default:
        begin
          state_nxt = rexs_pkg::ST_HELD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_r <= rexs_pkg::ST_HELD;
      hold_r <= 4'h0;
      armed_r <= 1'b0;
      ccr_r <= rexs_pkg::CCR_RST;
      pc_r <= rexs_pkg::PC_RST;
      fetch_r <= '0;
      prst_r <= 1'b1;
      run_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      hold_r <= hold_nxt;
      armed_r <= armed_nxt;
      ccr_r <= ccr_nxt;
      pc_r <= pc_nxt;
      fetch_r <= fetch_nxt;
      prst_r <= prst_nxt;
      run_r <= run_nxt;
    end
  end

  assign fetch_o = fetch_r;
  assign periph_rst_o = prst_r;
  assign cpu_run_o = run_r;
  assign condition_code_register_o = ccr_r;
  assign pc_o = pc_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_held_halts;
    @(posedge clk_i) disable iff (!rst_b_i)
    !pin_n_sync |=> (periph_rst_o && !cpu_run_o && !fetch_o.req);
  endproperty
  a_held_halts: assert property (p_held_halts) else $error("not halted while pin low");

  property p_short_pulse_ignored;
    @(posedge clk_i) disable iff (!rst_b_i)
    ($rose(pin_n_sync) && !armed_r) |=> state_r == rexs_pkg::ST_HELD;
  endproperty
  a_short_pulse_ignored: assert property (p_short_pulse_ignored) else $error("short pulse started sequence");

  property p_seq_starts;
    @(posedge clk_i) disable iff (!rst_b_i)
    (pin_n_sync && armed_r && state_r == rexs_pkg::ST_HELD) |=> state_r == rexs_pkg::ST_MASK;
  endproperty
  a_seq_starts: assert property (p_seq_starts) else $error("sequence did not start");

  property p_mask_first;
    @(posedge clk_i) disable iff (!rst_b_i)
    (fetch_o.req && fetch_o.addr == rexs_pkg::VEC_ADDR_HI) |-> condition_code_register_o[rexs_pkg::CCR_I_BIT];
  endproperty
  a_mask_first: assert property (p_mask_first) else $error("mask bit clear at vector fetch");

  property p_fetch_order;
    @(posedge clk_i) disable iff (!rst_b_i)
    (fetch_o.req && fetch_o.addr == rexs_pkg::VEC_ADDR_HI && pin_n_sync)
      |=> (fetch_o.req && fetch_o.addr == rexs_pkg::VEC_ADDR_LO);
  endproperty
  a_fetch_order: assert property (p_fetch_order) else $error("vector fetch order wrong");

  property p_pc_loaded;
    @(posedge clk_i) disable iff (!rst_b_i)
    (fetch_o.req && fetch_o.addr == rexs_pkg::VEC_ADDR_HI && pin_n_sync)
      ##1 pin_n_sync[*3] |=> (cpu_run_o && pc_o[7:0] == $past(fetch_data_i, 3));
  endproperty
  a_pc_loaded: assert property (p_pc_loaded) else $error("pc not loaded from vector");

  property p_run_after_fetch;
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(cpu_run_o) |-> $past(state_r, 1) == rexs_pkg::ST_LOAD;
  endproperty
  a_run_after_fetch: assert property (p_run_after_fetch) else $error("run without sequence");

  property p_sync_delay;
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(chip_init_pin_n_i) ##1 chip_init_pin_n_i |=> pin_n_sync;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync latency wrong");

  c_full_hold: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(armed_r));
  c_seq_run: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(cpu_run_o));
  c_reset_in_run: cover property (@(posedge clk_i) disable iff (!rst_b_i) cpu_run_o ##1 !pin_n_sync);
  c_short_pulse: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(pin_n_sync) && !armed_r);

endmodule

//--- rexs_supervisor.sv
/*
  far-side model: reset source driving the chip init pin, plus vector memory.
  assumes the testbench calls hold_low just after a rising clock edge.
*/
`timescale 1ns/1ps
module rexs_supervisor
(
  // clock
  input wire logic clk_i,
  // vector fetch
  input wire rexs_pkg::rexs_fetch_type fetch_i,
  output logic [7:0] data_o,
  // reset pin
  output logic pin_n_o
);
  logic [7:0] vec_hi = 8'h00;
  logic [7:0] vec_lo = 8'h00;

  // pin low from power-up until released
  initial pin_n_o = 1'b0;
  initial data_o = 8'h5A;

  // byte stands while the request stands, sampled at the next edge; else a changing pattern
  always @(posedge clk_i)
  begin
    #1;
    if (fetch_i.req === 1'b1)
      data_o = (fetch_i.addr == rexs_pkg::VEC_ADDR_HI) ? vec_hi : vec_lo;
    else
      data_o = ~data_o;
  end

  // pin low for n clock edges
  task automatic hold_low(input int n);
  begin
    pin_n_o = 1'b0;
    repeat (n) @(posedge clk_i);
    #1;
    pin_n_o = 1'b1;
  end
  endtask
endmodule

//--- test_rexs_sequencer.sv
/*
  testbench of the reset exception sequencer.
  assumes the supervisor model in rexs_supervisor.sv.
*/
`timescale 1ns/1ps
module test_rexs_sequencer;
  typedef struct {int len; logic [7:0] hi; logic [7:0] lo; logic run;} rexs_row_type;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic pin_n;
  logic [7:0] fdata;
  rexs_pkg::rexs_fetch_type fetch;
  logic periph_rst;
  logic cpu_run;
  logic [7:0] condition_code_register;
  logic [15:0] pc;
  logic [15:0] addr_log[$];
  logic [7:0] first_ccr;
  int err_count = 0;
  int checked = 0;
  rexs_row_type rows[4] = '{'{10, 8'h12, 8'h34, 1'b1}, '{9, 8'h56, 8'h78, 1'b0},
                            '{30, 8'hAB, 8'hCD, 1'b1}, '{10, 8'hFF, 8'h00, 1'b1}};

  always #5 clk_i = ~clk_i;

  rexs_sequencer i_rexs_sequencer (.clk_i(clk_i), .rst_b_i(rst_b_i), .chip_init_pin_n_i(pin_n),
    .fetch_o(fetch), .fetch_data_i(fdata), .periph_rst_o(periph_rst), .cpu_run_o(cpu_run),
    .condition_code_register_o(condition_code_register), .pc_o(pc));
  rexs_supervisor i_rexs_supervisor (.clk_i(clk_i), .fetch_i(fetch), .data_o(fdata), .pin_n_o(pin_n));

  // log of vector fetches
  always @(posedge clk_i)
  begin
    if (fetch.req === 1'b1)
    begin
      if (addr_log.size() == 0)
        first_ccr = condition_code_register;
      addr_log.push_back(fetch.addr);
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
  begin
    checked++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  end
  endtask

  task automatic test_done;
  begin
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  task automatic run_row(input rexs_row_type r);
    int i;
  begin
    i_rexs_supervisor.vec_hi = r.hi;
    i_rexs_supervisor.vec_lo = r.lo;
    addr_log.delete();
    i_rexs_supervisor.hold_low(r.len);
    chk(16'(periph_rst), 16'h0001);
    chk(16'(cpu_run), 16'h0000);
    for (i = 0; i < 20 && cpu_run !== 1'b1; i++)
      @(posedge clk_i);
    #1;
    if (r.run && cpu_run !== 1'b1)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, cpu_run, 1'b1);
      err_count++;
      test_done();
    end
    repeat (3) @(posedge clk_i);
    #1;
    chk(16'(cpu_run), 16'(r.run));
    chk(16'(periph_rst), 16'(!r.run));
    if (r.run)
    begin
      chk(pc, {r.hi, r.lo});
      chk(16'(first_ccr[rexs_pkg::CCR_I_BIT]), 16'h0001);
      chk(16'(addr_log.size()), 16'h0002);
      chk(addr_log[0], rexs_pkg::VEC_ADDR_HI);
      chk(addr_log[1], rexs_pkg::VEC_ADDR_LO);
    end
  end
  endtask

  initial
  begin
    repeat (16) @(posedge clk_i);
    #1;
    chk(16'(periph_rst), 16'h0001);
    chk(16'(condition_code_register), 16'(rexs_pkg::CCR_RST));
    chk(pc, rexs_pkg::PC_RST);
    rst_b_i = 1'b1;
    i_rexs_supervisor.hold_low(1);
    repeat (20) @(posedge clk_i);
    #1;
    chk(16'(cpu_run), 16'h0000);
    foreach (rows[k])
      run_row(rows[k]);
    // abort in the load step, after the vector fetch, then recover
    i_rexs_supervisor.hold_low(10);
    repeat (4) @(posedge clk_i);
    #1;
    run_row('{2, 8'h11, 8'h22, 1'b0});
    run_row('{12, 8'h9A, 8'hBC, 1'b1});
    // second reset while running
    rst_b_i = 1'b0;
    #2;
    chk(16'(cpu_run), 16'h0000);
    chk(16'(periph_rst), 16'h0001);
    chk(pc, rexs_pkg::PC_RST);
    test_done();
  end
endmodule
